/* File: rtl/mwc_consts.vh */
// Constants for the window and miscellaneous configuration register group.
// Assumes an 8-bit register index bus and a 125 MHz system clock.
`ifndef MWC_CONSTS_VH
`define MWC_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// Register indexes
`define MWC_IDX_EXT_HI        8'h6e
`define MWC_IDX_MISC_MEM      8'h6f
`define MWC_IDX_MISC_PIN      8'h70
`define MWC_IDX_WIN_A_DEV     8'h71

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define MWC_RST_EXT_HI        8'h00
`define MWC_RST_MISC_MEM      8'h00
`define MWC_RST_MISC_PIN      8'h00
`define MWC_RST_WIN_A_DEV     8'h00
`define MWC_RDATA_UNMAPPED    8'h00

////////////////////////////////////////////////////////////////////////////////
// Field positions, misc memory/dma/reset register
`define MWC_RANGE_MSB         7
`define MWC_RANGE_LSB         4
`define MWC_BIT_READ_DELAY    3
`define MWC_BIT_DMA_WAIT      2
`define MWC_BIT_CPU_RESET     1
`define MWC_BIT_A20_CTRL      0

// Field positions, misc pin/power register
`define MWC_BIT_GP0_DIR       6
`define MWC_BIT_SW_AC         5

////////////////////////////////////////////////////////////////////////////////
// Device type encoding per page
`define MWC_DEV_ROMDOS        2'h0
`define MWC_DEV_DRAM          2'h1
`define MWC_DEV_RESERVED      2'h2
`define MWC_DEV_BIOS          2'h3

////////////////////////////////////////////////////////////////////////////////
// Timing counts
`define MWC_CPU_RST_CYCLES    16
`define MWC_DMA_WAIT_LONG     2
`define MWC_DMA_WAIT_SHORT    1
`define MWC_MEMR_DELAY_CYC    1

`endif

/* File: rtl/mwc_cpu_reset_pulse.v */
// Rising-edge triggered CPU reset pulse generator.
// Assumes the processor clock runs on i_sys_clk; the pulse length is a count of it.
`include "mwc_consts.vh"

module mwc_cpu_reset_pulse #(
  parameter PULSE_CYCLES = `MWC_CPU_RST_CYCLES
) (
  input  wire i_sys_clk,
  input  wire i_resetn,
  input  wire i_clk_en,
  input  wire i_trigger_bit,
  output reg  o_cpu_reset
);

  reg       prev_bit_r;
  reg [5:0] count_r;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detect and countdown; a level held at 1 never retriggers
  always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      prev_bit_r  <= 1'b0;
      count_r     <= 6'h00;
      o_cpu_reset <= 1'b0;
    end else if (i_clk_en) begin
      prev_bit_r <= i_trigger_bit;
      if (i_trigger_bit && !prev_bit_r) begin
        count_r     <= PULSE_CYCLES[5:0] - 6'h01;
        o_cpu_reset <= 1'b1;
      end else if (count_r != 6'h00) begin
        count_r <= count_r - 6'h01;
      end else begin
        o_cpu_reset <= 1'b0;
      end
    end
  end

endmodule

/* File: rtl/mwc_regs.v */
// Window address extension, device select and miscellaneous control registers.
// Assumes a same-clock register master, pins synchronised here, and the
// region select bit and memory size coming from neighbouring register blocks.
`include "mwc_consts.vh"

module mwc_regs #(
  parameter RST_CYCLES = `MWC_CPU_RST_CYCLES
) (
  input  wire       i_sys_clk,
  input  wire       i_resetn,
  input  wire       i_clk_en,
  // Register port
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rdata,
  // Region select bit from the window B control register
  input  wire       i_region_select_bit,
  // Address extension copies and window A device types
  output reg  [7:0] o_ext_hi_win_a,
  output reg  [7:0] o_ext_hi_win_b,
  output reg  [3:0] o_win_a_romdos,
  output reg  [3:0] o_win_a_dram,
  output reg  [3:0] o_win_a_bios,
  // Direct memory cycle steering
  input  wire [4:0] i_onboard_mb,
  input  wire       i_mem_req,
  input  wire       i_window_cycle,
  input  wire [3:0] i_mem_addr_mb,
  output reg        o_to_dram,
  output reg        o_to_isa,
  output reg        o_onboard_off,
  // DMA transfer timing
  input  wire       i_dma_start,
  output reg        o_dma_memr,
  output reg        o_dma_wait,
  output reg        o_dma_done,
  // CPU reset and A20
  output wire       o_cpu_reset,
  input  wire       i_cpu_a20_a,
  input  wire       i_port92_bit0,
  input  wire       i_a20_gate_pin,
  output reg        o_a20,
  // General pin 0
  input  wire       i_gp_pin0,
  input  wire       i_gp_pin0_data,
  output reg        o_gp_pin0,
  output reg        o_gp_pin0_oe_n,
  output reg        o_gp_pin0_in,
  // Power manager inputs
  input  wire       i_ac_power_pin,
  input  wire [4:0] i_battery_low_pins_n,
  output reg        o_pm_ac_power,
  output reg  [4:0] o_pm_battery_low_n
);

  // DMA sequencer states, one-hot
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_DELAY = 4'b0010;
  localparam [3:0] ST_WAIT  = 4'b0100;
  localparam [3:0] ST_DONE  = 4'b1000;

  // Wait counts at the width of the counter they load
  localparam [1:0] WAIT_LONG  = `MWC_DMA_WAIT_LONG;
  localparam [1:0] WAIT_SHORT = `MWC_DMA_WAIT_SHORT;

  reg [7:0] ext_hi_a_r;
  reg [7:0] ext_hi_b_r;
  reg [7:0] misc_mem_r;
  reg [7:0] misc_pin_r;
  reg [7:0] win_a_dev_r;
  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [1:0] wait_cnt_r;
  reg [1:0] wait_cnt_nxt;
  reg [1:0] a20_pin_s_r;
  reg [1:0] gp0_s_r;
  reg [1:0] ac_s_r;
  reg [4:0] bl0_s_r;
  reg [4:0] bl1_s_r;
  reg [3:0] romdos_nxt;
  reg [3:0] dram_nxt;
  reg [3:0] bios_nxt;
  integer   pg;

  wire [3:0] range_mb   = misc_mem_r[`MWC_RANGE_MSB:`MWC_RANGE_LSB];
  wire       wr_ext     = i_wr && (i_addr == `MWC_IDX_EXT_HI);
  wire       range_full = ({1'b0, range_mb} >= i_onboard_mb);
  wire [4:0] dram_limit = i_onboard_mb - {1'b0, range_mb};

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // True when a page's two-bit device field holds the given code
  function is_dev;
    input [7:0] field;
    input [1:0] page;
    input [1:0] code;
    begin
      is_dev = (field[{page, 1'b1}] == code[1]) && (field[{page, 1'b0}] == code[0]);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; the extension register has one copy per window
  always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      ext_hi_a_r  <= `MWC_RST_EXT_HI;
      ext_hi_b_r  <= `MWC_RST_EXT_HI;
      misc_mem_r  <= `MWC_RST_MISC_MEM;
      misc_pin_r  <= `MWC_RST_MISC_PIN;
      win_a_dev_r <= `MWC_RST_WIN_A_DEV;
    end else if (i_clk_en && i_wr) begin
      if (wr_ext && !i_region_select_bit) begin
        ext_hi_a_r <= i_wdata;
      end
      if (wr_ext && i_region_select_bit) begin
        ext_hi_b_r <= i_wdata;
      end
      if (i_addr == `MWC_IDX_MISC_MEM) begin
        misc_mem_r <= i_wdata;
      end
      if (i_addr == `MWC_IDX_MISC_PIN) begin
        misc_pin_r <= i_wdata;
      end
      if (i_addr == `MWC_IDX_WIN_A_DEV) begin
        win_a_dev_r <= i_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port; data stands only in the cycle after the strobe
  always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_rdata <= `MWC_RDATA_UNMAPPED;
    end else if (i_clk_en) begin
      if (i_rd) begin
        case (i_addr)
          `MWC_IDX_EXT_HI:    o_rdata <= i_region_select_bit ? ext_hi_b_r : ext_hi_a_r;
          `MWC_IDX_MISC_MEM:  o_rdata <= misc_mem_r;
          `MWC_IDX_MISC_PIN:  o_rdata <= misc_pin_r;
          `MWC_IDX_WIN_A_DEV: o_rdata <= win_a_dev_r;
          default:            o_rdata <= `MWC_RDATA_UNMAPPED;
        endcase
      end else begin
        o_rdata <= `MWC_RDATA_UNMAPPED;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage feeds any logic
  always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      a20_pin_s_r <= 2'h0;
      gp0_s_r     <= 2'h0;
      ac_s_r      <= 2'h0;
      bl0_s_r     <= 5'h1f;
      bl1_s_r     <= 5'h1f;
    end else if (i_clk_en) begin
      a20_pin_s_r <= {a20_pin_s_r[0], i_a20_gate_pin};
      gp0_s_r     <= {gp0_s_r[0], i_gp_pin0};
      ac_s_r      <= {ac_s_r[0], i_ac_power_pin};
      bl0_s_r     <= i_battery_low_pins_n;
      bl1_s_r     <= bl0_s_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Device type decode per page of window A
  always @* begin
    romdos_nxt = 4'h0;
    dram_nxt   = 4'h0;
    bios_nxt   = 4'h0;
    for (pg = 0; pg < 4; pg = pg + 1) begin
      romdos_nxt[pg] = is_dev(win_a_dev_r, pg[1:0], `MWC_DEV_ROMDOS);
      dram_nxt[pg]   = is_dev(win_a_dev_r, pg[1:0], `MWC_DEV_DRAM);
      bios_nxt[pg]   = is_dev(win_a_dev_r, pg[1:0], `MWC_DEV_BIOS);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered copies of configuration and pin-facing outputs
  always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_ext_hi_win_a     <= `MWC_RST_EXT_HI;
      o_ext_hi_win_b     <= `MWC_RST_EXT_HI;
      o_win_a_romdos     <= 4'hf;
      o_win_a_dram       <= 4'h0;
      o_win_a_bios       <= 4'h0;
      o_a20              <= 1'b0;
      o_gp_pin0          <= 1'b0;
      o_gp_pin0_oe_n     <= 1'b1;
      o_gp_pin0_in       <= 1'b0;
      o_pm_ac_power      <= 1'b0;
      o_pm_battery_low_n <= 5'h1f;
    end else if (i_clk_en) begin
      o_ext_hi_win_a <= ext_hi_a_r;
      o_ext_hi_win_b <= ext_hi_b_r;
      o_win_a_romdos <= romdos_nxt;
      o_win_a_dram   <= dram_nxt;
      o_win_a_bios   <= bios_nxt;
      // A20 passes through while any of the three enables is high
      o_a20 <= i_cpu_a20_a && (misc_mem_r[`MWC_BIT_A20_CTRL] || i_port92_bit0 || a20_pin_s_r[1]);
      o_gp_pin0      <= i_gp_pin0_data;
      o_gp_pin0_oe_n <= ~misc_pin_r[`MWC_BIT_GP0_DIR];
      o_gp_pin0_in   <= gp0_s_r[1];
      o_pm_ac_power  <= ac_s_r[1] || misc_pin_r[`MWC_BIT_SW_AC];
      // Battery pins bypass the software AC bit entirely
      o_pm_battery_low_n <= bl1_s_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direct cycle steering; answer one cycle after the request
  always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_to_dram     <= 1'b0;
      o_to_isa      <= 1'b0;
      o_onboard_off <= 1'b0;
    end else if (i_clk_en) begin
      // A zero range leaves the full on-board size for DRAM
      o_onboard_off <= (range_mb != 4'h0) && range_full;
      if (i_mem_req && range_mb != 4'h0 && range_full) begin
        o_to_dram <= 1'b0;
        o_to_isa  <= 1'b1;
      end else if (i_mem_req && !i_window_cycle) begin
        o_to_dram <= ({1'b0, i_mem_addr_mb} < dram_limit);
        o_to_isa  <= ({1'b0, i_mem_addr_mb} >= dram_limit);
      end else begin
        o_to_dram <= 1'b0;
        o_to_isa  <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // DMA sequencer: optional strobe delay, then one or two wait cycles
  always @* begin
    state_nxt    = state_r;
    wait_cnt_nxt = wait_cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (i_dma_start) begin
          wait_cnt_nxt = misc_mem_r[`MWC_BIT_DMA_WAIT] ? WAIT_LONG : WAIT_SHORT;
          state_nxt    = misc_mem_r[`MWC_BIT_READ_DELAY] ? ST_DELAY : ST_WAIT;
        end
      end
      ST_DELAY: begin
        state_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        wait_cnt_nxt = wait_cnt_r - 2'h1;
        if (wait_cnt_r == 2'h1) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt    = ST_IDLE;
        wait_cnt_nxt = 2'h0;
      end
    endcase
  end

  // Outputs follow the next state so they leave flip-flops in step with it
  always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      state_r    <= ST_IDLE;
      wait_cnt_r <= 2'h0;
      o_dma_memr <= 1'b0;
      o_dma_wait <= 1'b0;
      o_dma_done <= 1'b0;
    end else if (i_clk_en) begin
      state_r    <= state_nxt;
      wait_cnt_r <= wait_cnt_nxt;
      o_dma_memr <= (state_nxt == ST_WAIT) || (state_nxt == ST_DONE);
      o_dma_wait <= (state_nxt == ST_DELAY) || (state_nxt == ST_WAIT);
      o_dma_done <= (state_nxt == ST_DONE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CPU reset pulse from the reset bit
  mwc_cpu_reset_pulse #(
    .PULSE_CYCLES (RST_CYCLES)
  ) u_cpu_reset (
    .i_sys_clk     (i_sys_clk),
    .i_resetn      (i_resetn),
    .i_clk_en      (i_clk_en),
    .i_trigger_bit (misc_mem_r[`MWC_BIT_CPU_RESET]),
    .o_cpu_reset   (o_cpu_reset)
  );

endmodule

/* File: verification/mwc_regs_monitor.sv */
// Assertion checker for the window and misc configuration register group.
// Assumes i_clk_en is held high; bound onto every mwc_regs instance.
module mwc_regs_monitor #(
  parameter int RST_CYCLES = 16
) (
  input wire logic       i_sys_clk,
  input wire logic       i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_mem_req,
  input wire logic       o_to_dram,
  input wire logic       o_to_isa,
  input wire logic       o_dma_memr,
  input wire logic       o_dma_wait,
  input wire logic       o_dma_done,
  input wire logic       o_cpu_reset,
  input wire logic       i_port92_bit0,
  input wire logic       i_a20_gate_pin,
  input wire logic       o_a20,
  input wire logic       o_gp_pin0_oe_n,
  input wire logic       o_pm_ac_power
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mis_r;
  logic [7:0] pin_r;
  int         cnt_r;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  ////////////////////////////////////////
  // Shadows of the misc registers, so checks need no peek inside
  always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      mis_r <= 8'h00;
      pin_r <= 8'h00;
    end else if (i_wr && i_addr == 8'h6f) begin
      mis_r <= i_wdata;
    end else if (i_wr && i_addr == 8'h70) begin
      pin_r <= i_wdata;
    end
  end

  // Length of the running CPU reset pulse, zero while idle
  always @(posedge i_sys_clk) begin
    if (!i_resetn || !o_cpu_reset) begin
      cnt_r <= 0;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end

  // Last transfer cycle, then strobe and done both drop
  sequence s_done_tail;
    (o_dma_memr && !o_dma_wait) ##1 (!o_dma_memr && !o_dma_done);
  endsequence

  ////////////////////////////////////////
  a_rdata_idle: assert property (o_rdata != 8'h00 |-> $past(i_rd))
    else $error("read data outside read answer cycle");
  a_rd_misc: assert property ($past(i_rd && i_addr == 8'h6f) |-> o_rdata == $past(mis_r))
    else $error("misc register read back wrong");
  a_steer_noreq: assert property (!$past(i_mem_req) |-> !o_to_dram && !o_to_isa)
    else $error("steering answer without request");
  a_steer_excl: assert property (!(o_to_dram && o_to_isa))
    else $error("cycle steered to both targets");
  a_cpu_rst_len: assert property ($fell(o_cpu_reset) |-> cnt_r == RST_CYCLES)
    else $error("CPU reset pulse length wrong");
  a_dma_done_tail: assert property (o_dma_done |-> s_done_tail)
    else $error("DMA done cycle malformed");
  a_a20_forced: assert property ((!mis_r[0] && !i_port92_bit0 && !i_a20_gate_pin)[*4] |-> !o_a20)
    else $error("A20 not forced low");
  a_gp_dir: assert property ($stable(pin_r[6])[*2] |-> o_gp_pin0_oe_n == !pin_r[6])
    else $error("pin 0 direction wrong");
  a_sw_ac: assert property (pin_r[5][*2] |-> o_pm_ac_power)
    else $error("software AC input ignored");
endmodule

bind mwc_regs mwc_regs_monitor #(.RST_CYCLES(RST_CYCLES)) i_mon (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_mem_req(i_mem_req), .o_to_dram(o_to_dram), .o_to_isa(o_to_isa),
  .o_dma_memr(o_dma_memr), .o_dma_wait(o_dma_wait), .o_dma_done(o_dma_done), .o_cpu_reset(o_cpu_reset),
  .i_port92_bit0(i_port92_bit0), .i_a20_gate_pin(i_a20_gate_pin), .o_a20(o_a20),
  .o_gp_pin0_oe_n(o_gp_pin0_oe_n), .o_pm_ac_power(o_pm_ac_power)
);

/* File: verification/mem_window_misc_config_regs_tb_top.sv */
// Self-checking bench for the window and misc configuration registers.
// Assumes the design files and the bound checker are compiled first.
module mem_window_misc_config_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RSTC = 4;
  logic        clk, rstn, wr, rd, sel, mreq, wcyc, dstart, cpua, p92, gate, gpin, gdat, acp;
  logic        todram, toisa, ooff, memr, dwait, ddone, cpurst, a20, gpo, gpoe_n, gpi, pmac, off;
  logic [7:0]  addr, wdata, rdata, exta, extb, d, e, ext_a, ext_b;
  logic [7:0]  rm [4];
  logic [4:0]  obmb, batt, pbatt;
  logic [3:0]  maddr, romdos, dram, bios, er, ed, eb, rng;
  logic [15:0] seed;
  int          num_errors, checks, cyc, k, fm, fd, nd, nw, lim;

  // Short reset pulse keeps the run quick
  mwc_regs #(.RST_CYCLES(RSTC)) i_dut (
    .i_sys_clk(clk), .i_resetn(rstn), .i_clk_en(1'h1), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_region_select_bit(sel), .o_ext_hi_win_a(exta), .o_ext_hi_win_b(extb),
    .o_win_a_romdos(romdos), .o_win_a_dram(dram), .o_win_a_bios(bios), .i_onboard_mb(obmb),
    .i_mem_req(mreq), .i_window_cycle(wcyc), .i_mem_addr_mb(maddr), .o_to_dram(todram), .o_to_isa(toisa),
    .o_onboard_off(ooff), .i_dma_start(dstart), .o_dma_memr(memr), .o_dma_wait(dwait), .o_dma_done(ddone),
    .o_cpu_reset(cpurst), .i_cpu_a20_a(cpua), .i_port92_bit0(p92), .i_a20_gate_pin(gate), .o_a20(a20),
    .i_gp_pin0(gpin), .i_gp_pin0_data(gdat), .o_gp_pin0(gpo), .o_gp_pin0_oe_n(gpoe_n), .o_gp_pin0_in(gpi),
    .i_ac_power_pin(acp), .i_battery_low_pins_n(batt), .o_pm_ac_power(pmac), .o_pm_battery_low_n(pbatt)
  );

  ////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Idle edge first so two strobes never land in one time step
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'h0;
    if (a == 8'h6e && sel) ext_b = v;
    else if (a == 8'h6e) ext_a = v;
    else if (a >= 8'h6f && a <= 8'h71) rm[a - 8'h6e] = v;
  endtask

  // Expectation taken after the edge, so a select changed just before has landed
  task automatic rd_chk(input logic [7:0] a);
    @(posedge clk);
    e = (a == 8'h6e) ? (sel ? ext_b : ext_a) : (a >= 8'h6f && a <= 8'h71) ? rm[a - 8'h6e] : 8'h00;
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    chk(rdata, e);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // Free-running system clock
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    {rstn, wr, rd, sel, mreq, wcyc, dstart, cpua, p92, gate, gpin, gdat, acp} = '0;
    {addr, wdata, maddr, ext_a, ext_b} = '0;
    rm = '{default: 8'h00};
    obmb = 5'h08;
    batt = 5'h1f;
    seed = 16'h2e5e;
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    // Defaults, unmapped neighbours included
    for (int a = 8'h6d; a <= 8'h72; a++) rd_chk(8'(a));
    chk({romdos, bios}, 8'hf0);
    // Both window copies, picked by the region select bit
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      @(posedge clk);
      sel <= i[0];
      if (i < 4) wr_reg(8'h6e, seed[7:0]);
      rd_chk(8'h6e);
    end
    chk(exta, ext_a);
    chk(extb, ext_b);
    // Device type decode, two fixed patterns putting every code on two pages, then a random one
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      d = (i == 0) ? 8'he4 : (i == 1) ? 8'h1b : seed[7:0];
      wr_reg(8'h71, d);
      @(posedge clk);
      #1;
      for (int p = 0; p < 4; p++) begin
        er[p] = d[2*p+:2] == 2'h0;
        ed[p] = d[2*p+:2] == 2'h1;
        eb[p] = d[2*p+:2] == 2'h3;
      end
      chk({romdos, dram}, {er, ed});
      chk({4'h0, bios}, {4'h0, eb});
      rd_chk(8'h71);
    end
    // Carve-out steering: none, partial, equal and above on-board size
    for (int i = 0; i < 4; i++) begin
      rng = (i == 0) ? 4'h0 : (i == 1) ? 4'h2 : (i == 2) ? 4'h8 : 4'hf;
      wr_reg(8'h6f, {rng, 4'h0});
      lim = 8 - rng;
      off = rng != 0 && rng >= 8;
      for (int a = 0; a < 16; a++) begin
        @(posedge clk);
        mreq <= 1'h1;
        maddr <= 4'(a);
        wcyc <= a[0];
        @(posedge clk);
        mreq <= 1'h0;
        #1;
        chk({todram, toisa}, {!off && !a[0] && a < lim, off || (!a[0] && a >= lim)});
      end
      chk({7'h0, ooff}, {7'h0, off});
    end
    // DMA timing per delay and wait setting, with a start repeated while busy
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h6f, {4'h0, i[1], i[0], 2'h0});
      @(posedge clk);
      dstart <= 1'h1;
      fm = 0;
      fd = 0;
      nd = 0;
      nw = 0;
      for (k = 0; k < 10; k++) begin
        @(posedge clk);
        dstart <= (k == 0);
        #1;
        if (dwait) nw++;
        if (memr && fm == 0) fm = k + 1;
        if (ddone) nd++;
        if (ddone) fd = k + 1;
      end
      chk(8'(fm), 8'(i[1] + 1));
      chk(8'(fd * 4 + nd), 8'((i[1] + i[0] + 2) * 4 + 1));
      chk(8'(nw), 8'(i[1] + i[0] + 1));
    end
    // CPU reset bit written 1, 1 again, 0, then 1
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h6f, (i == 2) ? 8'h00 : 8'h02);
      k = 0;
      repeat (24) begin
        @(posedge clk);
        #1;
        k += cpurst;
      end
      chk(8'(k), (i == 0 || i == 3) ? 8'(RSTC) : 8'h00);
    end
    // Gate control against every port and pin combination
    for (int i = 0; i < 16; i++) begin
      wr_reg(8'h6f, {7'h0, i[0]});
      @(posedge clk);
      p92 <= i[1];
      gate <= i[2];
      cpua <= i[3];
      repeat (4) @(posedge clk);
      #1;
      chk({7'h0, a20}, {7'h0, i[3] && (i[0] || i[1] || i[2])});
    end
    // Pin direction, software AC input and battery pins
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr_reg(8'h70, {1'h0, i[1], i[0], 5'h0});
      @(posedge clk);
      gpin <= i[0];
      gdat <= !i[0];
      acp <= i[1] && !i[0];
      batt <= seed[4:0];
      repeat (4) @(posedge clk);
      #1;
      chk({5'h0, gpoe_n, gpo, gpi}, {5'h0, !i[1], !i[0], i[0]});
      chk({2'h0, pmac, pbatt}, {2'h0, i[0] || i[1], seed[4:0]});
      rd_chk(8'h70);
    end
    summarize();
  end
endmodule
